//--- verilog/psf_pkg.sv
// Package for the program status flags block
package psf_pkg;
  localparam logic [7:0] PSF_SFR_ADDR   = 8'hd0;
  localparam logic [7:0] PSF_RESET_VAL  = 8'h00;
  localparam int         PSF_BIT_CARRY  = 7;
  localparam int         PSF_BIT_HALF   = 6;
  localparam int         PSF_BIT_USER0  = 5;
  localparam int         PSF_BIT_BANK_H = 4;
  localparam int         PSF_BIT_BANK_L = 3;
  localparam int         PSF_BIT_WRAP   = 2;
  localparam int         PSF_BIT_USER1  = 1;
  localparam int         PSF_BIT_PARITY = 0;
  localparam logic [7:0] PSF_BYTE_MAX   = 8'hff;
  localparam logic [4:0] PSF_BANK_BASE_STEP = 5'h08;

  typedef enum logic [2:0] {
    PSF_OP_NONE  = 3'h0,
    PSF_OP_ADD   = 3'h1,
    PSF_OP_ADD_CARRY  = 3'h3,
    PSF_OP_SUB_BORROW = 3'h2,
    PSF_OP_MULTIPLY   = 3'h6,
    PSF_OP_DIV   = 3'h7,
    PSF_OP_OTHER = 3'h5
  } psf_op_e;

  typedef struct packed {
    psf_op_e    op;
    logic [7:0] a;
    logic [7:0] b;
  } psf_alu_s;

  typedef struct packed {
    logic       wr_en;
    logic       bit_en;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } psf_sfr_s;
endpackage : psf_pkg

//--- verilog/psf_status.sv
// Program status word: arithmetic flags, user flags, bank select, parity
//
// Contract
// RULE1 - Carry is set on carry out of an add or borrow of a subtract, and cleared by other arithmetic.
// RULE2 - Half-byte carry is set on carry into or borrow from the upper nibble, and cleared by other arithmetic.
// RULE3 - Bits 5 and 1 are software flags, written by byte or bit access and never changed by hardware.
// RULE4 - Bank select in bits 4:3 picks the register bank base 0x00, 0x08, 0x10 or 0x18.
// RULE5 - Signed wrap flag is set when add, add with carry or subtract with borrow overflows two's complement.
// RULE6 - Signed wrap flag is set when a multiply product exceeds 255.
// RULE7 - Signed wrap flag is set when a divide has a zero divisor.
// RULE8 - Add, add with carry, subtract with borrow, multiply and divide clear the wrap flag otherwise.
// RULE9 - Bit 0 is read-only odd parity of the accumulator, tracked continuously.
// RULE10 - The status word sits at SFR address 0xd0, byte and bit addressable, zero after reset.
// RULE11 - A byte write updates every writable bit and the parity position ignores the written value.
`timescale 1ns/10ps
module psf_status
  import psf_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire psf_alu_s alu_in,
  input  wire logic [7:0] acc_value,
  input  wire psf_sfr_s sfr_in,
  output logic [7:0]    sfr_rdata,
  output logic          carry_flag,
  output logic          half_byte_carry_flag,
  output logic          signed_wrap_flag,
  output logic [1:0]    bank_select,
  output logic [4:0]    bank_base
);

  // Reset synchroniser
  logic        rst_sync1_reg;
  logic        rst_sync1_next;
  logic        rst_sync2_reg;
  logic        rst_sync2_next;
  logic        rst_int_n;

  // Stored status word
  logic [7:0]  status_reg;
  logic [7:0]  status_next;

  // Registered views of the word
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [4:0]  base_reg;
  logic [4:0]  base_next;
  logic        parity_reg;
  logic        parity_next;

  // Arithmetic terms
  logic        carry_in;
  logic [8:0]  add_full;
  logic [4:0]  add_low;
  logic [8:0]  sub_full;
  logic [4:0]  sub_low;
  logic [15:0] product;
  logic        add_wrap;
  logic        sub_wrap;
  logic        mul_wrap;
  logic        div_wrap;

  // Decoded operation
  logic        op_add;
  logic        op_add_carry;
  logic        op_sub_borrow;
  logic        op_multiply;
  logic        op_divide;
  logic        op_other;
  logic        op_any;
  logic        op_sets_wrap;

  // Software access
  logic        sel_hit;
  logic        byte_write;
  logic        bit_write;
  logic [7:0]  bit_mask;
  logic [7:0]  write_word;

  // Flag results of this cycle's arithmetic
  logic        carry_calc;
  logic        half_calc;
  logic        wrap_calc;

  // Reset release
  always_comb begin
    rst_sync1_next = 1'b1;
    rst_sync2_next = rst_sync1_reg;
  end

  // Two flops so every state flop leaves reset on the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= rst_sync1_next;
      rst_sync2_reg <= rst_sync2_next;
    end
  end

  assign rst_int_n = rst_sync2_reg;

  // Operation decode
  always_comb begin
    op_add        = 1'b0;
    op_add_carry  = 1'b0;
    op_sub_borrow = 1'b0;
    op_multiply   = 1'b0;
    op_divide     = 1'b0;
    op_other      = 1'b0;
    case (alu_in.op)
      PSF_OP_ADD: begin
        op_add = 1'b1;
      end
      PSF_OP_ADD_CARRY: begin
        op_add_carry = 1'b1;
      end
      PSF_OP_SUB_BORROW: begin
        op_sub_borrow = 1'b1;
      end
      PSF_OP_MULTIPLY: begin
        op_multiply = 1'b1;
      end
      PSF_OP_DIV: begin
        op_divide = 1'b1;
      end
      PSF_OP_OTHER: begin
        op_other = 1'b1;
      end
      default: begin
        op_add = 1'b0;
      end
    endcase
    op_any       = op_add | op_add_carry | op_sub_borrow | op_multiply | op_divide | op_other;
    // Other arithmetic leaves the wrap flag alone
    op_sets_wrap = op_any & ~op_other; // RULE8
  end

  // Adders, subtractors and the product
  always_comb begin
    // Only the chained forms take the stored carry as carry or borrow in
    carry_in = (op_add_carry | op_sub_borrow) & status_reg[PSF_BIT_CARRY];
    add_full = {1'b0, alu_in.a} + {1'b0, alu_in.b} + {8'h00, carry_in};
    add_low  = {1'b0, alu_in.a[3:0]} + {1'b0, alu_in.b[3:0]} + {4'h0, carry_in};
    sub_full = {1'b0, alu_in.a} - {1'b0, alu_in.b} - {8'h00, carry_in};
    sub_low  = {1'b0, alu_in.a[3:0]} - {1'b0, alu_in.b[3:0]} - {4'h0, carry_in};
    product  = {8'h00, alu_in.a} * {8'h00, alu_in.b};
    add_wrap = (alu_in.a[7] == alu_in.b[7]) && (add_full[7] != alu_in.a[7]); // RULE5
    sub_wrap = (alu_in.a[7] != alu_in.b[7]) && (sub_full[7] != alu_in.a[7]); // RULE5
    mul_wrap = (product[15:8] != 8'h00); // RULE6
    div_wrap = (alu_in.b == 8'h00); // RULE7
  end

  // Flag values this operation leaves behind
  always_comb begin
    // Multiply, divide and other arithmetic leave both carries clear
    carry_calc = 1'b0;
    half_calc  = 1'b0;
    wrap_calc  = 1'b0;
    if (op_add || op_add_carry) begin
      carry_calc = add_full[8]; // RULE1
      half_calc  = add_low[4]; // RULE2
      wrap_calc  = add_wrap; // RULE5
    end else if (op_sub_borrow) begin
      carry_calc = sub_full[8]; // RULE1
      half_calc  = sub_low[4]; // RULE2
      wrap_calc  = sub_wrap; // RULE5
    end else if (op_multiply) begin
      wrap_calc = mul_wrap; // RULE6
    end else if (op_divide) begin
      wrap_calc = div_wrap; // RULE7
    end
  end

  // Software access decode
  always_comb begin
    sel_hit    = sfr_in.wr_en && (sfr_in.addr == PSF_SFR_ADDR); // RULE10
    byte_write = sel_hit && !sfr_in.bit_en; // RULE11
    bit_write  = sel_hit && sfr_in.bit_en; // RULE3
    bit_mask   = 8'h01 << sfr_in.bit_sel;
    write_word = {8{sfr_in.wdata[0]}};
  end

  // Next status word
  always_comb begin
    status_next = status_reg;
    // Software first; arithmetic in the same cycle then owns its flags
    if (byte_write) begin
      status_next = sfr_in.wdata; // RULE11
    end else if (bit_write) begin
      status_next = (status_reg & ~bit_mask) | (write_word & bit_mask); // RULE3
    end
    if (op_any) begin
      status_next[PSF_BIT_CARRY] = carry_calc; // RULE1
      status_next[PSF_BIT_HALF]  = half_calc; // RULE2
    end
    if (op_sets_wrap) begin
      status_next[PSF_BIT_WRAP] = wrap_calc; // RULE8
    end
    // Stored parity slot stays clear; the live bit joins on read
    status_next[PSF_BIT_PARITY] = 1'b0; // RULE11
  end

  // Status word register
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      status_reg <= PSF_RESET_VAL; // RULE10
    end else begin
      status_reg <= status_next;
    end
  end

  // Parity of the accumulator
  always_comb begin
    // Follows the accumulator every cycle, not only on writes
    parity_next = ^acc_value; // RULE9
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      parity_reg <= 1'b0;
    end else begin
      parity_reg <= parity_next;
    end
  end

  // Bank base address
  always_comb begin
    // Eight registers per bank, so the base is the select shifted by three
    base_next = {status_next[PSF_BIT_BANK_H:PSF_BIT_BANK_L], 3'h0}; // RULE4
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      base_reg <= 5'h00;
    end else begin
      base_reg <= base_next;
    end
  end

  // Read view of the word
  always_comb begin
    rdata_next = {status_next[7:1], parity_next}; // RULE9
  end

  // Registered from the next word, so reads change on the same edge as the stored word
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rdata_reg <= PSF_RESET_VAL; // RULE10
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Every output straight from a flop
  assign sfr_rdata            = rdata_reg;
  assign carry_flag           = status_reg[PSF_BIT_CARRY];
  assign half_byte_carry_flag = status_reg[PSF_BIT_HALF];
  assign signed_wrap_flag     = status_reg[PSF_BIT_WRAP];
  assign bank_select          = status_reg[PSF_BIT_BANK_H:PSF_BIT_BANK_L]; // RULE4
  assign bank_base            = base_reg;

endmodule : psf_status

//--- testbench/psf_core_model.sv
// Core side model: arithmetic events and accumulator value
`timescale 1ns/10ps
module psf_core_model
  import psf_pkg::*;
(
  output psf_alu_s   alu_in,
  output logic [7:0] acc_value
);
  initial alu_in = '0;
  initial acc_value = 8'h00;
  // Bench calls this once a cycle, so an event never lingers past its cycle
  task automatic put(input psf_op_e op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] acc);
    alu_in = '{op, a, b};
    acc_value = acc;
  endtask : put
endmodule : psf_core_model

//--- testbench/psf_status_asserts.sv
// Assertions on the program status flags block ports
`timescale 1ns/10ps
module psf_status_asserts
  import psf_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire psf_alu_s   alu_in,
  input wire logic [7:0] acc_value,
  input wire psf_sfr_s   sfr_in,
  input wire logic [7:0] sfr_rdata,
  input wire logic       carry_flag,
  input wire logic       half_byte_carry_flag,
  input wire logic       signed_wrap_flag,
  input wire logic [1:0] bank_select,
  input wire logic [4:0] bank_base
);
  logic [8:0] s;
  logic [1:0] up_reg;
  logic v, m, z, hit;
  psf_op_e o;
  assign o = alu_in.op;
  assign s = alu_in.a + alu_in.b;
  assign v = alu_in.a[7] == alu_in.b[7] && s[7] != alu_in.a[7];
  assign m = 16'(alu_in.a) * alu_in.b > 16'hff;
  assign z = alu_in.b == 8'h00;
  assign hit = sfr_in.wr_en && sfr_in.addr == PSF_SFR_ADDR;
  // Outputs sit at zero while the reset synchroniser drains
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_carry; o == PSF_OP_ADD |=> carry_flag == $past(s[8]); endproperty
  a_carry: assert property (p_carry) else $error("carry after add");
  property p_wrap_add; o == PSF_OP_ADD |=> signed_wrap_flag == $past(v); endproperty
  a_wrap_add: assert property (p_wrap_add) else $error("wrap after add");
  property p_multiply; o == PSF_OP_MULTIPLY |=> signed_wrap_flag == $past(m) && !carry_flag; endproperty
  a_multiply: assert property (p_multiply) else $error("wrap after multiply");
  property p_div; o == PSF_OP_DIV |=> signed_wrap_flag == $past(z) && !half_byte_carry_flag; endproperty
  a_div: assert property (p_div) else $error("wrap after divide");
  property p_par; up_reg == 2'h3 |-> sfr_rdata[0] == ^$past(acc_value); endproperty
  a_par: assert property (p_par) else $error("parity bit");
  property p_bk; bank_base == {bank_select, 3'h0} && sfr_rdata[4:3] == bank_select; endproperty
  a_bk: assert property (p_bk) else $error("bank base");
  property p_wr; hit && !sfr_in.bit_en && o == PSF_OP_NONE |=> sfr_rdata[7:1] == $past(sfr_in.wdata[7:1]); endproperty
  a_wr: assert property (p_wr) else $error("byte write");
  property p_keep; !hit |=> $stable({sfr_rdata[5:3], sfr_rdata[1]}); endproperty
  a_keep: assert property (p_keep) else $error("software bits moved");
  c_multiply: cover property (o == PSF_OP_MULTIPLY && m);
  c_div: cover property (o == PSF_OP_DIV && z);
  c_bit: cover property (hit && sfr_in.bit_en);
endmodule : psf_status_asserts
bind psf_status psf_status_asserts u_chk (.clk, .rst_n, .alu_in, .acc_value, .sfr_in, .sfr_rdata, .carry_flag,
  .half_byte_carry_flag, .signed_wrap_flag, .bank_select, .bank_base);

//--- testbench/test_program_status_flags.sv
// Self-checking bench for the program status flags block
`timescale 1ns/10ps
module test_program_status_flags
  import psf_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  psf_sfr_s sfr_in = '0;
  psf_alu_s alu_in;
  logic [7:0] acc_value, sfr_rdata, m, acc;
  logic carry_seen, half_seen, wrap_seen;
  logic [1:0] bs;
  logic [4:0] bb;
  int mismatches = 0;
  int cmp_count = 0;
  int r, a, b, c;
  psf_op_e op;
  initial forever #5 clk = ~clk;
  psf_status dut (.clk, .rst_n, .alu_in, .acc_value, .sfr_in, .sfr_rdata, .carry_flag(carry_seen),
    .half_byte_carry_flag(half_seen), .signed_wrap_flag(wrap_seen), .bank_select(bs), .bank_base(bb));
  psf_core_model core (.alu_in, .acc_value);
  task automatic chk(input string n, input logic [17:0] x, input logic [17:0] y);
    cmp_count++;
    if (x !== y) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    r = $urandom(32'hb9980a2e);
    m = 8'h00;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("reset", 18'h0, {sfr_rdata, carry_seen, half_seen, wrap_seen, bs, bb});
    $display("reset test done");
    for (int i = 0; i < 600; i++) begin
      r = $urandom;
      // Code 4 is unused, so it stands in for an idle core cycle with a write
      op = psf_op_e'(r[2:0] == 3'h4 ? 3'h0 : r[2:0]);
      a = $urandom_range(255);
      b = r[5:3] == 3'h0 ? 0 : $urandom_range(255);
      acc = 8'($urandom);
      if (op == PSF_OP_NONE) sfr_in = '{1'b1, r[8], r[9] ? PSF_SFR_ADDR : 8'(r[23:16]), 3'(r[12:10]), 8'(a)};
      else sfr_in = '0;
      core.put(op, 8'(a), 8'(b), acc);
      c = m[7];
      if (sfr_in.wr_en && sfr_in.addr == PSF_SFR_ADDR && !sfr_in.bit_en) m[7:1] = sfr_in.wdata[7:1];
      else if (sfr_in.wr_en && sfr_in.addr == PSF_SFR_ADDR && sfr_in.bit_sel != 3'h0) m[sfr_in.bit_sel] = sfr_in.wdata[0];
      if (op != PSF_OP_NONE) m[7:6] = 2'h0;
      if (op == PSF_OP_ADD) c = 0;
      if (op == PSF_OP_ADD || op == PSF_OP_ADD_CARRY) m[7:6] = {a + b + c > 255, a % 16 + b % 16 + c > 15};
      if (op == PSF_OP_ADD || op == PSF_OP_ADD_CARRY) m[2] = (a ^ b) < 128 && ((a + b + c) ^ a) & 128;
      if (op == PSF_OP_SUB_BORROW) m[7:6] = {a < b + c, a % 16 < b % 16 + c};
      if (op == PSF_OP_SUB_BORROW) m[2] = (a ^ b) >= 128 && ((a - b - c) ^ a) & 128;
      if (op == PSF_OP_MULTIPLY) m[2] = a * b > 255;
      if (op == PSF_OP_DIV) m[2] = b == 0;
      @(posedge clk);
      #1 chk("ports", {m[7:1], ^acc, m[7:6], m[2], m[4:3], m[4:3], 3'h0},
             {sfr_rdata, carry_seen, half_seen, wrap_seen, bs, bb});
    end
    $display("random test done");
    end_sim();
  end
endmodule : test_program_status_flags
